// ---- core/adc_cfg_pkg.sv ----
package adc_cfg_pkg;
	// register addresses
	localparam logic [3:0] ADDR_GEN_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TIMING = 4'h1;
	localparam logic [3:0] ADDR_FIXED_PAIR = 4'h2;
	localparam logic [3:0] ADDR_DIFF_MASK = 4'h3;
	localparam logic [3:0] ADDR_SINGLE_LO = 4'h4;
	localparam logic [3:0] ADDR_SINGLE_HI = 4'h5;
	localparam logic [3:0] ADDR_MONITOR = 4'h6;
	localparam logic [3:0] ADDR_PORT_DIR = 4'h7;
	localparam logic [3:0] ADDR_PORT_LEVEL = 4'h8;
	localparam logic [3:0] ADDR_DEV_ID = 4'h9;
	localparam int unsigned NUM_RW_REGS = 9;

	// reset values
	localparam logic [7:0] RST_GEN_CTRL = 8'h0A;
	localparam logic [7:0] RST_TIMING = 8'h83;
	localparam logic [7:0] RST_FIXED_PAIR = 8'h00;
	localparam logic [7:0] RST_DIFF_MASK = 8'h00;
	localparam logic [7:0] RST_SINGLE_LO = 8'hFF;
	localparam logic [7:0] RST_SINGLE_HI = 8'hFF;
	localparam logic [7:0] RST_MONITOR = 8'h00;
	localparam logic [7:0] RST_PORT_DIR = 8'hFF;
	localparam logic [7:0] RST_PORT_LEVEL = 8'h00;

	// writable bits; reserved bits read zero
	localparam logic [7:0] WMASK_GEN_CTRL = 8'h7E;
	localparam logic [7:0] WMASK_MONITOR = 8'h3D;
	localparam logic [7:0] WMASK_FULL = 8'hFF;

	// general control fields
	localparam int unsigned BIT_IDLE_RST = 6;
	localparam int unsigned BIT_SCAN_MODE = 5;
	localparam int unsigned BIT_BYPASS = 4;
	localparam int unsigned BIT_CLK_OUT = 3;
	localparam int unsigned BIT_CHOP = 2;
	localparam int unsigned BIT_STAT = 1;

	// timing control fields
	localparam int unsigned BIT_IDLE_MODE = 7;
	localparam int unsigned DLY_MSB = 6;
	localparam int unsigned DLY_LSB = 4;
	localparam int unsigned BIAS_MSB = 3;
	localparam int unsigned BIAS_LSB = 2;
	localparam int unsigned RATE_MSB = 1;
	localparam int unsigned RATE_LSB = 0;

	// command byte
	localparam logic [2:0] CMD_REG_READ = 3'h2;
	localparam logic [2:0] CMD_REG_WRITE = 3'h3;
	localparam int unsigned BIT_MULTI = 4;

	// monitor channel ids that use the internal path in scan mode
	localparam logic [4:0] CHID_SUPPLY = 5'h1A;
	localparam logic [4:0] CHID_TEMP = 5'h1B;
	localparam logic [4:0] CHID_GAIN = 5'h1C;
	localparam logic [4:0] CHID_REF = 5'h1D;

	// serial idle timeouts in master clock cycles
	localparam int unsigned IDLE_LONG_CYCLES = 4096;
	localparam int unsigned IDLE_SHORT_CYCLES = 256;
endpackage

// ---- core/spi_link_if.sv ----
interface spi_link_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [7:0] tx_byte;
	logic tx_load;
	logic link_clear;
	logic short_idle;

	modport shifter(
		output rx_byte, rx_valid, link_clear,
		input tx_byte, tx_load, short_idle
	);
	modport core(
		input rx_byte, rx_valid, link_clear,
		output tx_byte, tx_load, short_idle
	);
endinterface

// ---- core/serial_link_shifter.sv ----
module serial_link_shifter #(
	parameter int unsigned LONG_IDLE = adc_cfg_pkg::IDLE_LONG_CYCLES,
	parameter int unsigned SHORT_IDLE = adc_cfg_pkg::IDLE_SHORT_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// core side
	spi_link_if.shifter link
);
	localparam int unsigned IDLE_W = $clog2(LONG_IDLE + 1);
	localparam logic [IDLE_W-1:0] LONG_LAST = IDLE_W'(LONG_IDLE - 1);
	localparam logic [IDLE_W-1:0] SHORT_LAST = IDLE_W'(SHORT_IDLE - 1);

	logic [1:0] cs_s_q;
	logic [1:0] sclk_s_q;
	logic [1:0] mosi_s_q;
	logic sclk_prev_q;
	logic [IDLE_W-1:0] idle_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic miso_q;

	wire cs_act = !cs_s_q[1];
	wire sclk_rise = sclk_s_q[1] && !sclk_prev_q;
	wire sclk_fall = !sclk_s_q[1] && sclk_prev_q;
	wire sclk_edge = sclk_rise || sclk_fall;
	wire [IDLE_W-1:0] idle_last = link.short_idle ? SHORT_LAST : LONG_LAST;
	wire idle_hit = cs_act && !sclk_edge && (idle_q == idle_last);
	wire link_clear = !cs_act || idle_hit;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cs_s_q <= 2'h3;
			sclk_s_q <= 2'h0;
			mosi_s_q <= 2'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_s_q <= {cs_s_q[0], cs_n_i};
			sclk_s_q <= {sclk_s_q[0], sclk_i};
			mosi_s_q <= {mosi_s_q[0], mosi_i};
			sclk_prev_q <= sclk_s_q[1];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || link_clear || sclk_edge) begin
			idle_q <= '0;
		end else begin
			idle_q <= idle_q + IDLE_W'(1);
		end
	end

	// timeout clears the shifter state and returns the core to command
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || link_clear) begin
			bit_cnt_q <= 3'h0;
			rx_sh_q <= 7'h00;
			tx_sh_q <= 8'h00;
			miso_q <= 1'b0;
		end else begin
			if (sclk_fall) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				rx_sh_q <= {rx_sh_q[5:0], mosi_s_q[1]};
			end
			if (link.tx_load) begin
				tx_sh_q <= link.tx_byte;
			end else if (sclk_rise) begin
				miso_q <= tx_sh_q[7];
				tx_sh_q <= {tx_sh_q[6:0], 1'b0};
			end
		end
	end

	assign link.rx_valid = cs_act && sclk_fall && (bit_cnt_q == 3'h7);
	assign link.rx_byte = {rx_sh_q, mosi_s_q[1]};
	assign link.link_clear = link_clear;
	assign miso_o = miso_q;
	assign miso_oe_o = cs_act;

	// quiet span counted apart from the timeout counter
	logic [IDLE_W-1:0] quiet_q;
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !cs_act || sclk_edge) begin
			quiet_q <= '0;
		end else if (quiet_q != '1) begin
			quiet_q <= quiet_q + IDLE_W'(1);
		end
	end

	property p_idle_timeout;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(cs_act && !sclk_edge && quiet_q == (link.short_idle ? SHORT_LAST : LONG_LAST)) |-> link_clear;
	endproperty
	a_idle_timeout: assert property (p_idle_timeout) else $error("idle limit reached without link clear");

	property p_no_early_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(cs_act && quiet_q < (link.short_idle ? SHORT_LAST : LONG_LAST)) |-> !link_clear;
	endproperty
	a_no_early_clear: assert property (p_no_early_clear) else $error("link cleared before idle limit");

	property p_timeout_clears;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(cs_act && idle_hit) |=> (bit_cnt_q == 3'h0) && (idle_q == '0) && !link.rx_valid;
	endproperty
	a_timeout_clears: assert property (p_timeout_clears) else $error("timeout left shifter state");
endmodule

// ---- core/adc_config_register_bank.sv ----
module adc_config_register_bank #(
	// arbitrary identifier value
	parameter logic [7:0] ID_CODE = 8'h5A,
	parameter int unsigned LONG_IDLE = adc_cfg_pkg::IDLE_LONG_CYCLES,
	parameter int unsigned SHORT_IDLE = adc_cfg_pkg::IDLE_SHORT_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// clock pin control
	input wire logic clock_source_pin_i,
	output logic clock_io_pin_oe_o,
	// channel selection
	input wire logic [4:0] conv_channel_id_i,
	output logic fixed_mode_o,
	output logic [7:0] diff_scan_mask_o,
	output logic [15:0] single_scan_mask_o,
	output logic [7:0] monitor_scan_mask_o,
	output logic [3:0] positive_input_sel_o,
	output logic [3:0] negative_input_sel_o,
	output logic ext_input_route_o,
	// conversion settings
	output logic chop_enable_o,
	output logic idle_sleep_o,
	output logic [2:0] switch_delay_o,
	output logic [1:0] bias_current_sel_o,
	output logic [1:0] rate_code_o,
	// status byte framing
	output logic cmd_read_status_o,
	output logic direct_read_status_o,
	output logic status_undefined_o,
	// port pin registers
	output logic [7:0] port_pin_direction_o,
	output logic [7:0] port_pin_level_o
);
	localparam logic [8:0][7:0] REG_RESET = {
		adc_cfg_pkg::RST_PORT_LEVEL, adc_cfg_pkg::RST_PORT_DIR,
		adc_cfg_pkg::RST_MONITOR, adc_cfg_pkg::RST_SINGLE_HI,
		adc_cfg_pkg::RST_SINGLE_LO, adc_cfg_pkg::RST_DIFF_MASK,
		adc_cfg_pkg::RST_FIXED_PAIR, adc_cfg_pkg::RST_TIMING,
		adc_cfg_pkg::RST_GEN_CTRL
	};
	localparam logic [8:0][7:0] REG_WMASK = {
		adc_cfg_pkg::WMASK_FULL, adc_cfg_pkg::WMASK_FULL,
		adc_cfg_pkg::WMASK_MONITOR, adc_cfg_pkg::WMASK_FULL,
		adc_cfg_pkg::WMASK_FULL, adc_cfg_pkg::WMASK_FULL,
		adc_cfg_pkg::WMASK_FULL, adc_cfg_pkg::WMASK_FULL,
		adc_cfg_pkg::WMASK_GEN_CTRL
	};

	typedef enum logic [1:0] {
		ST_CMD,
		ST_READ,
		ST_WRITE
	} xfer_state_e;

	xfer_state_e state_q;
	xfer_state_e state_d;
	logic [3:0] addr_q;
	logic [3:0] addr_d;
	logic mul_q;
	logic mul_d;
	logic [8:0][7:0] regs_q;
	logic [1:0] clk_src_s_q;
	logic [7:0] diff_q;
	logic [15:0] single_q;
	logic [7:0] monitor_q;
	logic [3:0] pos_q;
	logic [3:0] neg_q;
	logic route_q;
	logic clk_oe_q;
	logic direct_stat_q;

	spi_link_if link_bus();

	serial_link_shifter #(
		.LONG_IDLE(LONG_IDLE),
		.SHORT_IDLE(SHORT_IDLE)
	) u_shifter (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.cs_n_i(cs_n_i),
		.sclk_i(sclk_i),
		.mosi_i(mosi_i),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o),
		.link(link_bus.shifter)
	);

	// register read mux, also used for the identifier
	function automatic logic [7:0] reg_rd(input logic [8:0][7:0] regs, input logic [3:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == adc_cfg_pkg::ADDR_DEV_ID) begin
			v = ID_CODE;
		end else if (a < adc_cfg_pkg::ADDR_DEV_ID) begin
			v = regs[a];
		end
		return v;
	endfunction

	// channel ids routed internally in scan mode whatever the bypass bit
	function automatic logic is_internal_monitor(input logic [4:0] id);
		return (id == adc_cfg_pkg::CHID_SUPPLY) || (id == adc_cfg_pkg::CHID_TEMP) ||
			(id == adc_cfg_pkg::CHID_GAIN) || (id == adc_cfg_pkg::CHID_REF);
	endfunction

	// command decode
	wire rx_take = link_bus.rx_valid && !link_bus.link_clear;
	wire [2:0] rx_cmd = link_bus.rx_byte[7:5];
	wire [3:0] rx_addr = link_bus.rx_byte[3:0];
	wire rx_mul = link_bus.rx_byte[adc_cfg_pkg::BIT_MULTI];
	wire is_rd_cmd = (state_q == ST_CMD) && (rx_cmd == adc_cfg_pkg::CMD_REG_READ);
	wire is_wr_cmd = (state_q == ST_CMD) && (rx_cmd == adc_cfg_pkg::CMD_REG_WRITE);
	// multi access stops after the identifier
	wire more = mul_q && (addr_q < adc_cfg_pkg::ADDR_DEV_ID);
	wire [3:0] addr_next = addr_q + 4'h1;
	// identifier and unmapped addresses take no write
	wire wr_en = rx_take && (state_q == ST_WRITE) && (addr_q < adc_cfg_pkg::ADDR_DEV_ID);

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		mul_d = mul_q;
		if (link_bus.link_clear) begin
			state_d = ST_CMD;
		end else if (rx_take) begin
			unique case (state_q)
				ST_CMD: begin
					addr_d = rx_addr;
					mul_d = rx_mul;
					if (is_rd_cmd) begin
						state_d = ST_READ;
					end else if (is_wr_cmd) begin
						state_d = ST_WRITE;
					end
				end
				ST_READ, ST_WRITE: begin
					if (more) begin
						addr_d = addr_next;
					end else begin
						state_d = ST_CMD;
					end
				end
			endcase
		end
	end

	// read data staged for the next byte
	assign link_bus.tx_load = rx_take;
	assign link_bus.tx_byte = is_rd_cmd ? reg_rd(regs_q, rx_addr) :
		((state_q == ST_READ) && more) ? reg_rd(regs_q, addr_next) : 8'h00;
	assign link_bus.short_idle = regs_q[adc_cfg_pkg::ADDR_GEN_CTRL][adc_cfg_pkg::BIT_IDLE_RST];

	// only the transfer state returns to command
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_q <= ST_CMD;
			addr_q <= 4'h0;
			mul_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			mul_q <= mul_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < adc_cfg_pkg::NUM_RW_REGS; i++) begin
			if (!resetn_i) begin
				regs_q[i] <= REG_RESET[i];
			end else if (wr_en && (addr_q == 4'(i))) begin
				regs_q[i] <= link_bus.rx_byte & REG_WMASK[i];
			end
		end
	end

	// pin synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			clk_src_s_q <= 2'h0;
		end else begin
			clk_src_s_q <= {clk_src_s_q[0], clock_source_pin_i};
		end
	end

	wire [7:0] gen_w = regs_q[adc_cfg_pkg::ADDR_GEN_CTRL];
	wire [7:0] tim_w = regs_q[adc_cfg_pkg::ADDR_TIMING];
	wire fixed_w = gen_w[adc_cfg_pkg::BIT_SCAN_MODE];
	wire bypass_w = gen_w[adc_cfg_pkg::BIT_BYPASS];
	// scan masks only in scan mode
	wire [7:0] diff_d = fixed_w ? 8'h00 : regs_q[adc_cfg_pkg::ADDR_DIFF_MASK];
	wire [15:0] single_d = fixed_w ? 16'h0000 :
		{regs_q[adc_cfg_pkg::ADDR_SINGLE_HI], regs_q[adc_cfg_pkg::ADDR_SINGLE_LO]};
	wire [7:0] monitor_d = fixed_w ? 8'h00 : regs_q[adc_cfg_pkg::ADDR_MONITOR];
	// fixed pair only in fixed mode
	wire [3:0] pos_d = fixed_w ? regs_q[adc_cfg_pkg::ADDR_FIXED_PAIR][7:4] : 4'h0;
	wire [3:0] neg_d = fixed_w ? regs_q[adc_cfg_pkg::ADDR_FIXED_PAIR][3:0] : 4'h0;
	wire route_d = bypass_w && (fixed_w || !is_internal_monitor(conv_channel_id_i));
	// clock drive only when source pin low
	wire clk_oe_d = gen_w[adc_cfg_pkg::BIT_CLK_OUT] && !clk_src_s_q[1];
	// direct reads follow bit in scan mode only
	wire direct_stat_d = !fixed_w && gen_w[adc_cfg_pkg::BIT_STAT];

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			diff_q <= 8'h00;
			single_q <= 16'h0000;
			monitor_q <= 8'h00;
			pos_q <= 4'h0;
			neg_q <= 4'h0;
			route_q <= 1'b0;
			clk_oe_q <= 1'b0;
			direct_stat_q <= 1'b0;
		end else begin
			diff_q <= diff_d;
			single_q <= single_d;
			monitor_q <= monitor_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
			route_q <= route_d;
			clk_oe_q <= clk_oe_d;
			direct_stat_q <= direct_stat_d;
		end
	end

	assign diff_scan_mask_o = diff_q;
	assign single_scan_mask_o = single_q;
	assign monitor_scan_mask_o = monitor_q;
	assign positive_input_sel_o = pos_q;
	assign negative_input_sel_o = neg_q;
	assign ext_input_route_o = route_q;
	assign clock_io_pin_oe_o = clk_oe_q;
	assign direct_read_status_o = direct_stat_q;
	assign fixed_mode_o = fixed_w;
	assign chop_enable_o = gen_w[adc_cfg_pkg::BIT_CHOP];
	// command reads always framed with status
	assign cmd_read_status_o = 1'b1;
	assign status_undefined_o = fixed_w;
	assign idle_sleep_o = tim_w[adc_cfg_pkg::BIT_IDLE_MODE];
	assign switch_delay_o = tim_w[adc_cfg_pkg::DLY_MSB:adc_cfg_pkg::DLY_LSB];
	assign bias_current_sel_o = tim_w[adc_cfg_pkg::BIAS_MSB:adc_cfg_pkg::BIAS_LSB];
	assign rate_code_o = tim_w[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB];
	assign port_pin_direction_o = regs_q[adc_cfg_pkg::ADDR_PORT_DIR];
	assign port_pin_level_o = regs_q[adc_cfg_pkg::ADDR_PORT_LEVEL];

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	property p_scan_sources;
		!fixed_w |=> (positive_input_sel_o == 4'h0) && (negative_input_sel_o == 4'h0) &&
			(diff_scan_mask_o == $past(regs_q[3])) && (monitor_scan_mask_o == $past(regs_q[6]));
	endproperty
	a_scan_sources: assert property (p_scan_sources) else $error("scan mode selection wrong");

	property p_fixed_sources;
		fixed_w |=> (diff_scan_mask_o == 8'h00) && (single_scan_mask_o == 16'h0000) &&
			(monitor_scan_mask_o == 8'h00) && (positive_input_sel_o == $past(regs_q[2][7:4]));
	endproperty
	a_fixed_sources: assert property (p_fixed_sources) else $error("fixed mode selection wrong");

	property p_monitor_internal;
		(!fixed_w && is_internal_monitor(conv_channel_id_i)) |=> !ext_input_route_o;
	endproperty
	a_monitor_internal: assert property (p_monitor_internal) else $error("monitor routed external");

	property p_clock_input_only;
		clk_src_s_q[1] |=> !clock_io_pin_oe_o;
	endproperty
	a_clock_input_only: assert property (p_clock_input_only) else $error("clock pin driven as input");

	property p_direct_status;
		$past(resetn_i) |-> direct_read_status_o == ($past(gen_w[1]) && !$past(fixed_w));
	endproperty
	a_direct_status: assert property (p_direct_status) else $error("direct status framing wrong");

	sequence s_read_id_cmd;
		is_rd_cmd && rx_take && (rx_addr == adc_cfg_pkg::ADDR_DEV_ID);
	endsequence
	sequence s_in_id_read;
		(state_q == ST_READ) && (addr_q == adc_cfg_pkg::ADDR_DEV_ID);
	endsequence
	property p_read_id;
		s_read_id_cmd |-> (link_bus.tx_load && link_bus.tx_byte == ID_CODE) ##1 s_in_id_read;
	endproperty
	a_read_id: assert property (p_read_id) else $error("identifier read not staged");

	property p_auto_inc;
		(state_q == ST_WRITE && mul_q && addr_q < 4'h9 && rx_take) |=>
			(state_q == ST_WRITE) && (addr_q == $past(addr_q) + 4'h1);
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("multi write did not advance");

	property p_multi_end;
		(state_q != ST_CMD && addr_q == 4'h9 && rx_take) |=> (state_q == ST_CMD);
	endproperty
	a_multi_end: assert property (p_multi_end) else $error("access ran past identifier");

	property p_id_read_only;
		(state_q == ST_WRITE && addr_q == 4'h9 && rx_take) |=> $stable(regs_q);
	endproperty
	a_id_read_only: assert property (p_id_read_only) else $error("identifier write changed state");

	property p_clear_keeps_regs;
		link_bus.link_clear |=> (state_q == ST_CMD) && $stable(regs_q);
	endproperty
	a_clear_keeps_regs: assert property (p_clear_keeps_regs) else $error("link clear touched registers");
endmodule

// ---- dv/spi_host_model.sv ----
module spi_host_model (
	// clock
	input wire logic clk_sys_i,
	// serial pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic mosi_o,
	input wire logic miso_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// half of the 320 ns link period in master clock cycles
	localparam int HALF = 4;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end

	task automatic frame_start();
		@(posedge clk_sys_i);
		cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask

	// released data line shows the inverse of its last bit
	task automatic frame_end();
		repeat (HALF) @(posedge clk_sys_i);
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		repeat (8) @(posedge clk_sys_i);
	endtask

	// data out on rising edge, device samples on falling edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_sys_i);
			sclk_o <= 1'b1;
			mosi_o <= tx[i];
			repeat (HALF) @(posedge clk_sys_i);
			sclk_o <= 1'b0;
			repeat (HALF - 1) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			rx[i] = miso_i;
		end
	endtask
endmodule

// ---- dv/adc_config_register_bank_bench.sv ----
module adc_config_register_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// arbitrary identifier value
	localparam logic [7:0] ID_VAL = 8'h3C;
	localparam logic [7:0] RST_TAB [10] = '{8'h0A, 8'h83, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, ID_VAL};
	localparam logic [7:0] MW [7] = '{8'h81, 8'h12, 8'h34, 8'hFF, 8'h0F, 8'hF0, 8'h77};
	localparam logic [4:0] IDS [6] = '{5'h18, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h03};

	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clock_source_pin_i = 1'b0;
	logic [4:0] conv_channel_id_i = 5'h00;
	logic cs_n, sclk, mosi, miso, miso_oe, clk_oe, fixed_mode, ext_route, chop, sleep;
	logic cmd_stat, dir_stat, stat_undef;
	logic [7:0] diff_mask, mon_mask, port_dir, port_level, rx;
	logic [15:0] single_mask;
	logic [3:0] pos_sel, neg_sel;
	logic [2:0] dly;
	logic [1:0] bias, rate;
	int fail_count = 0;
	int compares = 0;

	always #20 clk_sys_i = ~clk_sys_i;

	adc_config_register_bank #(.ID_CODE(ID_VAL), .LONG_IDLE(64), .SHORT_IDLE(16)) dut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
		.clock_source_pin_i(clock_source_pin_i), .clock_io_pin_oe_o(clk_oe),
		.conv_channel_id_i(conv_channel_id_i), .fixed_mode_o(fixed_mode),
		.diff_scan_mask_o(diff_mask), .single_scan_mask_o(single_mask), .monitor_scan_mask_o(mon_mask),
		.positive_input_sel_o(pos_sel), .negative_input_sel_o(neg_sel), .ext_input_route_o(ext_route),
		.chop_enable_o(chop), .idle_sleep_o(sleep), .switch_delay_o(dly),
		.bias_current_sel_o(bias), .rate_code_o(rate),
		.cmd_read_status_o(cmd_stat), .direct_read_status_o(dir_stat), .status_undefined_o(stat_undef),
		.port_pin_direction_o(port_dir), .port_pin_level_o(port_level)
	);

	spi_host_model host (
		.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		host.frame_start();
		host.xfer({adc_cfg_pkg::CMD_REG_WRITE, 1'b0, a}, rx);
		host.xfer(d, rx);
		host.frame_end();
	endtask

	task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
		host.frame_start();
		host.xfer({adc_cfg_pkg::CMD_REG_READ, 1'b0, a}, rx);
		host.xfer(8'h00, rx);
		host.frame_end();
		check({8'h00, rx}, {8'h00, exp});
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		// multi read of the whole map, then a command in the same frame
		host.frame_start();
		host.xfer(8'h50, rx);
		check({15'h0, miso_oe}, 16'h0001);
		for (int a = 0; a < 10; a++) begin
			host.xfer(8'h00, rx);
			check({8'h00, rx}, {8'h00, RST_TAB[a]});
		end
		host.xfer(8'h49, rx);
		host.xfer(8'h00, rx);
		check({8'h00, rx}, {8'h00, ID_VAL});
		host.frame_end();
		check({15'h0, miso_oe}, 16'h0000);
		check({5'h00, fixed_mode, ext_route, chop, sleep, dly, bias, rate}, 16'h0083);
		check({4'h0, clk_oe, dir_stat, cmd_stat, stat_undef, pos_sel, neg_sel}, 16'h0E00);
		check(single_mask, 16'hFFFF);
		check({diff_mask, mon_mask}, 16'h0000);
		check({port_dir, port_level}, 16'hFF00);
		// reserved bits set on purpose
		reg_write(4'h0, 8'hFF);
		read_check(4'h0, 8'h7E);
		reg_write(4'h2, 8'hA5);
		check({2'h0, fixed_mode, ext_route, chop, clk_oe, dir_stat, stat_undef, pos_sel, neg_sel}, 16'h3DA5);
		check(single_mask, 16'h0000);
		check({diff_mask, mon_mask}, 16'h0000);
		clock_source_pin_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		check({15'h0, clk_oe}, 16'h0000);
		clock_source_pin_i <= 1'b0;
		// short idle limit: a brief stall survives, a long one clears
		host.frame_start();
		host.xfer(8'h61, rx);
		repeat (8) @(posedge clk_sys_i);
		host.xfer(8'h55, rx);
		host.xfer(8'h61, rx);
		repeat (24) @(posedge clk_sys_i);
		host.xfer(8'h41, rx);
		host.xfer(8'h00, rx);
		check({8'h00, rx}, 16'h0055);
		host.frame_end();
		reg_write(4'h0, 8'h12);
		// long idle limit now in force
		host.frame_start();
		host.xfer(8'h61, rx);
		repeat (40) @(posedge clk_sys_i);
		host.xfer(8'h5E, rx);
		host.xfer(8'h61, rx);
		repeat (80) @(posedge clk_sys_i);
		host.xfer(8'h41, rx);
		host.xfer(8'h00, rx);
		check({8'h00, rx}, 16'h005E);
		host.frame_end();
		check({4'h0, fixed_mode, clk_oe, dir_stat, stat_undef, pos_sel, neg_sel}, 16'h0200);
		check({8'h00, sleep, dly, bias, rate}, 16'h005E);
		// multi write ends at the identifier, then a command in the same frame
		host.frame_start();
		host.xfer(8'h73, rx);
		foreach (MW[i]) host.xfer(MW[i], rx);
		host.xfer(8'h42, rx);
		host.xfer(8'h00, rx);
		check({8'h00, rx}, 16'h00A5);
		host.frame_end();
		check({diff_mask, mon_mask}, 16'h813D);
		check(single_mask, 16'h3412);
		check({port_dir, port_level}, 16'h0FF0);
		read_check(4'h9, ID_VAL);
		read_check(4'hA, 8'h00);
		foreach (IDS[i]) begin
			conv_channel_id_i <= IDS[i];
			repeat (3) @(posedge clk_sys_i);
			check({15'h0, ext_route}, {15'h0, (IDS[i] < 5'h1A || IDS[i] > 5'h1D)});
		end
		end_sim();
	end
endmodule
